// *** rtl/sig_cfg.svh ***
// Purpose: offsets, fields, reset values and timing counts of the i2c channel
// Assumes: 25 MHz hclk, one word per register on AHB-Lite
// Notes:   constants only
`ifndef SIG_CFG_SVH
`define SIG_CFG_SVH

`define SIG_OFF_TMODE   8'h00
`define SIG_OFF_TDATA   8'h04
`define SIG_OFF_TSTART  8'h08
`define SIG_OFF_TSTAT   8'h0C
`define SIG_OFF_IFB     8'h10
`define SIG_OFF_MKB     8'h14
`define SIG_OFF_MKA     8'h18
`define SIG_OFF_IFA     8'h1C
`define SIG_OFF_BUF     8'h20
`define SIG_OFF_MAN     8'h24
`define SIG_OFF_SETUP   8'h28
`define SIG_OFF_GATE    8'h2C
`define SIG_OFF_SS      8'h30
`define SIG_OFF_STAT    8'h34
`define SIG_OFF_ST      8'h38
`define SIG_OFF_ENA     8'h3C
`define SIG_OFF_ERRCLR  8'h40
`define SIG_OFF_LINES   8'h44
`define SIG_OFF_WAIT    8'h48

`define SIG_BIT_TSTART  3
`define SIG_BIT_TIRQ    5
`define SIG_BIT_SIRQ    1
`define SIG_BIT_CKO     8
`define SIG_BIT_SO      0
`define SIG_BIT_BUSY    5
`define SIG_BIT_ACKERR  1
`define SIG_BIT_CH0     0

`define SIG_RST_TMODE   16'h0009
`define SIG_RST_MAN     16'h0101
`define SIG_RST_SETUP   16'h0017
`define SIG_RST_WAIT    4'h4
`define SIG_MODE_TX     2'h2
`define SIG_MODE_RX     2'h1
`define SIG_MODE_ONE    3'h4

`define SIG_HCLK_MHZ    25
`define SIG_CLK_NS      40
`define SIG_GAP_US      5
`define SIG_GAP_CYC     (`SIG_GAP_US * `SIG_HCLK_MHZ)
`define SIG_BIT_NS      5000
`define SIG_HALF_CYC    (`SIG_BIT_NS / (2 * `SIG_CLK_NS))

`endif

// *** rtl/sig_pkg.sv ***
// Purpose: types shared by the i2c channel
// Assumes: nothing
// Notes:   timing and offsets live in sig_cfg.svh
package sig_pkg;
  typedef struct packed {
    logic scl;
    logic sda;
  } sig_line_s;

  typedef enum logic [1:0] {
    SH_IDLE,
    SH_LOW,
    SH_HIGH
  } sig_shift_e;
endpackage

// *** rtl/sig_i2c.sv ***
// Purpose: simple i2c master channel with a one-count gap timer, AHB-Lite slave
// Assumes: open-drain lines resolved outside; line inputs asynchronous
// Notes:   zero-wait bus; manual line bits own the lines while the channel is off
// Notes on behaviour
// - gap timer counts down from loaded value
// - split select 0 gives one 16-bit count
// - trigger select 000 accepts software start only
// - count clock select 0 uses chosen operation clock
// - start bit sets enable status, starts count
// - write address byte 0x60 or 0x70
// - read address byte 0x61 or 0x71
// - stop: data low, clock high, data high
// - manual bits set line levels directly
// - mode code 00 disables communication
// - start: data high, clock high, data low, clock low
// - gap timed by flag clear then retrigger
// - flag rises at count end
// - transmit: output on, mode 10, then start; the bench sets mode 10 after the start trigger
// - mode 10 transmits without sampling data
// - start trigger sets enable, waits for data
// - transfer flag high only while shifting
// - stop trigger clears enable, halts channel
// - byte complete: clear flag, retrigger, unmask
// - mask bit 0 passes, 1 blocks request
// - ninth bit reports ack (0) or nack (1)
// - wait set number of gap counts per byte
// - one gap count period is 5 us
//
// Local design decisions: the register offsets and the AHB-Lite slave port.
`include "sig_cfg.svh"
module sig_i2c import sig_pkg::*; (
  // clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // i2c lines
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // masked requests
  output logic             gap_timer_irq,
  output logic             serial_irq
);
  // bus
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic [31:0] rd_mux;
  // registers
  logic [15:0] gap_timer_mode;
  logic [15:0] gap_timer_data;
  logic [15:0] manual_line_output;
  logic [15:0] channel_comm_setup;
  logic        serial_output_enable_bit;
  logic        channel_enable_status;
  logic        gap_timer_enable_status;
  logic        gap_timer_irq_flag;
  logic        gap_timer_irq_mask;
  logic        serial_irq_flag;
  logic        serial_irq_mask;
  logic        ack_error_flag;
  logic [3:0]  wait_target;
  logic [3:0]  wait_count;
  // gap timer
  logic [15:0] gap_cnt;
  logic        gap_run;
  logic [7:0]  presc;
  // shifter
  sig_shift_e  sh_state;
  logic [3:0]  bit_cnt;
  logic [7:0]  ph_cnt;
  logic [7:0]  shreg;
  logic        sh_scl;
  logic        sh_sda;
  sig_line_s   line_m;
  sig_line_s   line_s;

  // address phase accepted; write lands in the data phase
  wire addr_ok = hsel & htrans[1] & hready & ce;
  wire wr_en   = wr_pend & ce;
  assign hreadyout = ce;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else if (ce) begin
      wr_pend <= addr_ok & hwrite;
      wr_addr <= haddr[7:0];
      if (addr_ok && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  wire wr_tmode  = wr_en & (wr_addr == `SIG_OFF_TMODE);
  wire wr_tdata  = wr_en & (wr_addr == `SIG_OFF_TDATA);
  wire wr_tstart = wr_en & (wr_addr == `SIG_OFF_TSTART);
  wire wr_ifb    = wr_en & (wr_addr == `SIG_OFF_IFB);
  wire wr_mkb    = wr_en & (wr_addr == `SIG_OFF_MKB);
  wire wr_mka    = wr_en & (wr_addr == `SIG_OFF_MKA);
  wire wr_ifa    = wr_en & (wr_addr == `SIG_OFF_IFA);
  wire wr_buf    = wr_en & (wr_addr == `SIG_OFF_BUF);
  wire wr_man    = wr_en & (wr_addr == `SIG_OFF_MAN);
  wire wr_setup  = wr_en & (wr_addr == `SIG_OFF_SETUP);
  wire wr_gate   = wr_en & (wr_addr == `SIG_OFF_GATE);
  wire wr_ss     = wr_en & (wr_addr == `SIG_OFF_SS);
  wire wr_st     = wr_en & (wr_addr == `SIG_OFF_ST);
  wire wr_errclr = wr_en & (wr_addr == `SIG_OFF_ERRCLR);
  wire wr_wait   = wr_en & (wr_addr == `SIG_OFF_WAIT);

  wire ss_hit  = wr_ss & hwdata[`SIG_BIT_CH0];
  wire st_hit  = wr_st & hwdata[`SIG_BIT_CH0];

  // gap timer fields
  wire [1:0] op_clk_sel = gap_timer_mode[15:14];
  wire       cnt_clk_sel = gap_timer_mode[12];
  wire       split_sel = gap_timer_mode[11];
  wire [2:0] start_sel = gap_timer_mode[10:8];
  wire       one_count = (gap_timer_mode[3:1] == `SIG_MODE_ONE);
  wire       sw_start  = wr_tstart & hwdata[`SIG_BIT_TSTART];
  wire       gap_accept = sw_start & (start_sel == 3'h0) & one_count;
  // 8-bit split runs only the low half; full width otherwise
  wire [15:0] gap_load = split_sel ? {8'h00, gap_timer_data[7:0]} : gap_timer_data;
  wire tick_sel = (op_clk_sel == 2'h0) ? 1'b1 :
                  (op_clk_sel == 2'h1) ? (presc[1:0] == 2'h3) :
                  (op_clk_sel == 2'h2) ? (presc[3:0] == 4'hF) : (presc == 8'hFF);
  // external count clock is not wired here, so that choice holds the count
  wire gap_tick = tick_sel & ~cnt_clk_sel;
  wire gap_done = gap_run & gap_tick & (gap_cnt == 16'h0000);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc   <= 8'h00;
      gap_cnt <= 16'h0000;
      gap_run <= 1'b0;
      gap_timer_enable_status <= 1'b0;
    end else if (ce) begin
      presc <= presc + 8'h01;
      if (gap_accept) begin
        gap_cnt <= gap_load;
        gap_run <= 1'b1;
        gap_timer_enable_status <= 1'b1;
      end else if (gap_run && gap_tick) begin
        if (gap_cnt == 16'h0000) begin
          gap_run <= 1'b0;
        end else begin
          gap_cnt <= gap_cnt - 16'h0001;
        end
      end
    end
  end

  // channel fields
  wire [1:0] chan_mode = channel_comm_setup[15:14];
  wire mode_tx = (chan_mode == `SIG_MODE_TX);
  wire mode_rx = (chan_mode == `SIG_MODE_RX);
  wire busy    = (sh_state != SH_IDLE);
  // 00 and 11 leave the channel deaf to data writes
  wire go      = wr_buf & channel_enable_status & (mode_tx | mode_rx) & ~busy;
  wire ph_end  = (ph_cnt == 8'(`SIG_HALF_CYC - 1));
  wire last_bit = (bit_cnt == 4'h8);
  wire byte_done = (sh_state == SH_HIGH) & ph_end & last_bit;
  // transmit shifts in ones so the buffer never holds line samples
  wire in_bit  = mode_tx ? 1'b1 : line_s.sda;
  wire ninth   = ~mode_rx;

  // two flops on each line before anything reads it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_m <= '1;
      line_s <= '1;
    end else if (ce) begin
      line_m <= '{scl: scl_in, sda: sda_in};
      line_s <= line_m;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh_state <= SH_IDLE;
      bit_cnt  <= 4'h0;
      ph_cnt   <= 8'h00;
      shreg    <= 8'hFF;
      sh_scl   <= 1'b1;
      sh_sda   <= 1'b1;
    end else if (ce) begin
      if (ss_hit && !channel_enable_status) begin
        sh_scl <= manual_line_output[`SIG_BIT_CKO];
        sh_sda <= manual_line_output[`SIG_BIT_SO];
      end
      if (st_hit) begin
        sh_state <= SH_IDLE;
      end else if (go) begin
        // first byte is the address with direction bit set by software
        sh_state <= SH_LOW;
        shreg    <= hwdata[7:0];
        sh_sda   <= hwdata[7];
        sh_scl   <= 1'b0;
        bit_cnt  <= 4'h0;
        ph_cnt   <= 8'h00;
      end else if (busy) begin
        ph_cnt <= ph_end ? 8'h00 : ph_cnt + 8'h01;
        if (ph_end && sh_state == SH_LOW) begin
          sh_state <= SH_HIGH;
          sh_scl   <= 1'b1;
        end else if (ph_end && last_bit) begin
          sh_state <= SH_IDLE;
          sh_scl   <= 1'b0;
        end else if (ph_end) begin
          sh_state <= SH_LOW;
          sh_scl   <= 1'b0;
          shreg    <= {shreg[6:0], in_bit};
          sh_sda   <= (bit_cnt == 4'h7) ? ninth : shreg[6];
          bit_cnt  <= bit_cnt + 4'h1;
        end
      end
    end
  end

  // software-cleared flags: an event in the clearing cycle wins
  wire next_gap_flag  = gap_done | (wr_ifb ? hwdata[`SIG_BIT_TIRQ] : gap_timer_irq_flag);
  wire next_ser_flag  = byte_done | (wr_ifa ? hwdata[`SIG_BIT_SIRQ] : serial_irq_flag);
  wire next_ack_error = (byte_done & mode_tx) ? line_s.sda :
                        ((wr_errclr & hwdata[`SIG_BIT_ACKERR]) ? 1'b0 : ack_error_flag);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_timer_irq_flag <= 1'b0;
      serial_irq_flag    <= 1'b0;
      ack_error_flag     <= 1'b0;
      wait_count         <= 4'h0;
    end else if (ce) begin
      gap_timer_irq_flag <= next_gap_flag;
      serial_irq_flag    <= next_ser_flag;
      ack_error_flag     <= next_ack_error;
      if (byte_done) begin
        wait_count <= 4'h0;
      end else if (gap_done && wait_count != wait_target) begin
        wait_count <= wait_count + 4'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_timer_mode      <= `SIG_RST_TMODE;
      gap_timer_data      <= 16'(`SIG_GAP_CYC - 1);
      manual_line_output  <= `SIG_RST_MAN;
      channel_comm_setup  <= `SIG_RST_SETUP;
      serial_output_enable_bit <= 1'b0;
      channel_enable_status    <= 1'b0;
      gap_timer_irq_mask  <= 1'b1;
      serial_irq_mask     <= 1'b1;
      wait_target         <= `SIG_RST_WAIT;
    end else if (ce) begin
      if (wr_tmode) gap_timer_mode <= hwdata[15:0];
      if (wr_tdata) gap_timer_data <= hwdata[15:0];
      // locked while the shifter may own the lines
      if (wr_man && !channel_enable_status) begin
        manual_line_output <= hwdata[15:0] & `SIG_RST_MAN;
      end
      if (wr_setup) channel_comm_setup <= hwdata[15:0];
      if (wr_gate) serial_output_enable_bit <= hwdata[`SIG_BIT_CH0];
      if (wr_mkb) gap_timer_irq_mask <= hwdata[`SIG_BIT_TIRQ];
      if (wr_mka) serial_irq_mask <= hwdata[`SIG_BIT_SIRQ];
      if (wr_wait) wait_target <= hwdata[3:0];
      if (st_hit) begin
        channel_enable_status <= 1'b0;
      end else if (ss_hit) begin
        channel_enable_status <= 1'b1;
      end
    end
  end

  // masked requests
  assign gap_timer_irq = gap_timer_irq_flag & ~gap_timer_irq_mask;
  assign serial_irq    = serial_irq_flag & ~serial_irq_mask;

  // line levels: manual bits whenever the channel is off
  wire lvl_scl = channel_enable_status ? sh_scl : manual_line_output[`SIG_BIT_CKO];
  wire lvl_sda = (channel_enable_status & serial_output_enable_bit) ? sh_sda :
                 manual_line_output[`SIG_BIT_SO];
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = ~lvl_scl;
  assign sda_oe  = ~lvl_sda;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr[7:0])
      `SIG_OFF_TMODE:  rd_mux = {16'h0000, gap_timer_mode};
      `SIG_OFF_TDATA:  rd_mux = {16'h0000, gap_timer_data};
      `SIG_OFF_TSTAT:  rd_mux = {gap_cnt, 12'h000, gap_timer_enable_status, 3'h0};
      `SIG_OFF_IFB:    rd_mux = {26'h0, gap_timer_irq_flag, 5'h00};
      `SIG_OFF_MKB:    rd_mux = {26'h0, gap_timer_irq_mask, 5'h00};
      `SIG_OFF_MKA:    rd_mux = {30'h0, serial_irq_mask, 1'b0};
      `SIG_OFF_IFA:    rd_mux = {30'h0, serial_irq_flag, 1'b0};
      `SIG_OFF_BUF:    rd_mux = {24'h000000, shreg};
      `SIG_OFF_MAN:    rd_mux = {16'h0000, manual_line_output};
      `SIG_OFF_SETUP:  rd_mux = {16'h0000, channel_comm_setup};
      `SIG_OFF_GATE:   rd_mux = {31'h0, serial_output_enable_bit};
      `SIG_OFF_STAT:   rd_mux = {26'h0, busy, 3'h0, ack_error_flag, 1'b0};
      `SIG_OFF_ENA:    rd_mux = {31'h0, channel_enable_status};
      `SIG_OFF_LINES:  rd_mux = {30'h0, line_s.scl, line_s.sda};
      `SIG_OFF_WAIT:   rd_mux = {23'h0, (wait_count == wait_target), wait_count, wait_target};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_gap_load: assert property (gap_accept && ce |=> gap_run && gap_cnt == $past(gap_load))
    else $error("gap count not loaded");
  a_gap_split: assert property (gap_accept && ce && split_sel |=> gap_cnt[15:8] == 8'h00)
    else $error("split count has high half");
  a_trig_ignored: assert property (sw_start && start_sel != 3'h0 && !gap_run |=> !gap_run)
    else $error("non-software trigger started timer");
  a_clk_hold: assert property (gap_run && cnt_clk_sel && !gap_accept |=> $stable(gap_cnt))
    else $error("count moved without count clock");
  a_start_te: assert property (gap_accept && ce |=> gap_timer_enable_status)
    else $error("enable status not set");
  a_flag_end: assert property (gap_done && ce |=> gap_timer_irq_flag)
    else $error("flag missing at count end");
  a_manual_lvl: assert property (
    !channel_enable_status |-> scl_oe == !manual_line_output[`SIG_BIT_CKO])
    else $error("manual clock level not on pin");
  a_irq_block: assert property (
    gap_timer_irq |-> !gap_timer_irq_mask && gap_timer_irq_flag)
    else $error("masked request passed");
  a_ss_wait: assert property (ss_hit && ce && !st_hit |=> channel_enable_status && !busy)
    else $error("start trigger did not wait");
  a_stop_halt: assert property (st_hit && ce |=> !channel_enable_status && !busy)
    else $error("stop trigger did not halt");
  a_busy_go: assert property (go && !st_hit |=> busy ##1 busy)
    else $error("transfer flag low during transfer");
  a_tx_nosample: assert property (
    mode_tx && ph_end && sh_state == SH_HIGH && !last_bit && ce && !st_hit |=> shreg[0])
    else $error("transmit sampled data");
  a_ack_record: assert property (
    byte_done && mode_tx && ce |=> ack_error_flag == $past(line_s.sda))
    else $error("ack not recorded");
  a_man_lock: assert property (
    channel_enable_status && wr_man |=> $stable(manual_line_output))
    else $error("manual bits changed while running");
  a_mode_off: assert property (wr_buf && chan_mode == 2'h0 && !busy |=> !busy)
    else $error("disabled mode started transfer");

  c_tx_byte: cover property (byte_done && mode_tx);
  c_rx_byte: cover property (byte_done && mode_rx);
  c_gap_end: cover property (gap_done);
  c_split_load: cover property (gap_accept && split_sel);
  c_wait_full: cover property (gap_done && wait_count == wait_target - 4'h1);
endmodule

// *** test/sig_slave_model.sv ***
// Purpose: behavioural i2c slave facing the channel
// Assumes: open-drain lines with pull-ups resolved by the bench
// Notes:   acks addresses 0x6X/0x7X, serves one fixed byte per read
module sig_slave_model (
  // bus lines
  input  wire logic scl,
  input  wire logic sda,
  // data pull-down
  output logic      sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] RD_DATA = 8'hA5;
  logic [7:0] sh;
  int         n;
  logic       first;
  logic       rd;
  initial begin
    sda_oe = 1'b0;
    n = 0;
    first = 1'b0;
    rd = 1'b0;
    sh = 8'h00;
  end
  // data moving while clock is high marks start or stop
  always @(sda) begin
    // clock and data can move in one step; let the clock settle first
    #1;
    if (scl === 1'b1) begin
      n = 0;
      first = !sda;
      rd = 1'b0;
      sda_oe = 1'b0;
    end
  end
  always @(posedge scl) begin
    n = n + 1;
    if (n <= 8) sh = {sh[6:0], sda};
    if (first && n == 8) rd = sda;
  end
  // answers at once, so any master wait is long enough
  always @(negedge scl) begin
    if (n == 9) begin
      n = 0;
      first = 1'b0;
    end
    if (rd && !first && n < 8) sda_oe = !RD_DATA[7 - n];
    else if (n == 8) sda_oe = first ? (sh[7:5] == 3'b011) : !rd;
    else sda_oe = 1'b0;
  end
endmodule

// *** test/sig_i2c_tb.sv ***
// Purpose: self-checking bench for the i2c channel and its gap timer
// Assumes: AHB-Lite slave answers within 100 cycles, pull-ups on both lines
// Notes:   every wait is a bounded loop
`include "sig_cfg.svh"
module sig_i2c_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk;
  logic        hresetn;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        scl_oe;
  logic        sda_oe;
  logic        s_sda_oe;
  logic        gap_timer_irq;
  logic        serial_irq;
  wire         scl_w;
  wire         sda_w;
  logic [8:0]  cap;
  logic [31:0] rd;
  int          err_count;
  int          checks_done;
  assign scl_w = !scl_oe;
  assign sda_w = !(sda_oe | s_sda_oe);
  sig_i2c sig_i2c_i (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(),
    .sda_oe(sda_oe), .gap_timer_irq(gap_timer_irq), .serial_irq(serial_irq)
  );
  sig_slave_model sig_slave_model_i (.scl(scl_w), .sda(sda_w), .sda_oe(s_sda_oe));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // bit monitor: last eight data bits and the answer bit
  always @(posedge scl_w) cap <= {cap[7:0], sda_w};
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 100) begin
        err_count++;
        final_report;
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    wait_rdy;
    rd = hrdata;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, rd & m, e);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int k;
    k = 0;
    bus(1'b0, a, 32'h0);
    while ((rd & m) !== v) begin
      k++;
      if (k > 1000) begin
        err_count++;
        final_report;
      end
      bus(1'b0, a, 32'h0);
    end
  endtask
  task automatic lines(input logic [31:0] man, input string nm);
    bus(1'b1, `SIG_OFF_MAN, man);
    @(posedge hclk);
    chk(nm, {30'h0, scl_w, sda_w}, {30'h0, man[8], man[0]});
  endtask
  task automatic i2c_start;
    lines(32'h101, "idle lines");
    lines(32'h100, "start data low");
    lines(32'h000, "start clock low");
    bus(1'b1, `SIG_OFF_GATE, 32'h1);
    bus(1'b1, `SIG_OFF_SS, 32'h1);
    rchk("channel on", `SIG_OFF_ENA, 32'h1, 32'h1);
    bus(1'b1, `SIG_OFF_BUF, 32'h55);
    rchk("mode 00 refuses", `SIG_OFF_STAT, 32'h20, 32'h0);
    bus(1'b1, `SIG_OFF_SETUP, 32'h8017);
  endtask
  task automatic i2c_stop;
    bus(1'b1, `SIG_OFF_MAN, 32'h101);
    rchk("manual held", `SIG_OFF_MAN, 32'h101, 32'h0);
    bus(1'b1, `SIG_OFF_GATE, 32'h0);
    bus(1'b1, `SIG_OFF_ST, 32'h1);
    rchk("channel off", `SIG_OFF_ENA, 32'h1, 32'h0);
    rchk("stopped idle", `SIG_OFF_STAT, 32'h20, 32'h0);
    lines(32'h000, "stop data low");
    lines(32'h100, "stop clock high");
    lines(32'h101, "stop data high");
    bus(1'b1, `SIG_OFF_SETUP, 32'h0017);
  endtask
  task automatic tx_byte(input logic [7:0] b, input logic nack, input string nm);
    bus(1'b1, `SIG_OFF_IFA, 32'h0);
    bus(1'b1, `SIG_OFF_BUF, {24'h0, b});
    rchk("busy", `SIG_OFF_STAT, 32'h20, 32'h20);
    poll(`SIG_OFF_STAT, 32'h20, 32'h0);
    chk(nm, {24'h0, cap[8:1]}, {24'h0, b});
    rchk("ack flag", `SIG_OFF_STAT, 32'h2, {30'h0, nack, 1'b0});
    chk("serial irq", {31'h0, serial_irq}, 32'h1);
  endtask
  task automatic gap_run(input logic [15:0] md, input logic [15:0] dt, input int ex);
    int k;
    bus(1'b1, `SIG_OFF_TMODE, {16'h0, md});
    bus(1'b1, `SIG_OFF_TDATA, {16'h0, dt});
    bus(1'b1, `SIG_OFF_IFB, 32'h0);
    @(posedge hclk);
    chk("flag cleared", {31'h0, gap_timer_irq}, 32'h0);
    bus(1'b1, `SIG_OFF_TSTART, 32'h8);
    k = 0;
    // sample away from the launching edge, then realign for the bus
    while (gap_timer_irq !== 1'b1 && k < 700) begin
      @(negedge hclk);
      k++;
    end
    @(posedge hclk);
    if (ex == 0) chk("no count", k, 700);
    else chk("gap period", (k > ex - 8) && (k < ex + 8), 1);
  endtask
  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cap = 9'h000;
    rd = 32'h0;
    err_count = 0;
    checks_done = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk("mode reset", `SIG_OFF_TMODE, 32'hFFFF, 32'h0009);
    rchk("data reset", `SIG_OFF_TDATA, 32'hFFFF, 32'h007C);
    rchk("manual reset", `SIG_OFF_MAN, 32'h101, 32'h101);
    rchk("setup reset", `SIG_OFF_SETUP, 32'hFFFF, 32'h0017);
    rchk("gap mask reset", `SIG_OFF_MKB, 32'h20, 32'h20);
    rchk("serial mask reset", `SIG_OFF_MKA, 32'h2, 32'h2);
    rchk("wait reset", `SIG_OFF_WAIT, 32'hF, 32'h4);
    rchk("trigger reads 0", `SIG_OFF_TSTART, 32'hFFFFFFFF, 32'h0);
    rchk("unmapped", 8'h80, 32'hFFFFFFFF, 32'h0);
    chk("okay response", {31'h0, hresp}, 32'h0);
    $display("test reset values done");
    bus(1'b1, `SIG_OFF_MKB, 32'h0);
    gap_run(16'h0009, 16'h007C, 125);
    rchk("timer enabled", `SIG_OFF_TSTAT, 32'h8, 32'h8);
    bus(1'b1, `SIG_OFF_MKB, 32'h20);
    @(posedge hclk);
    chk("masked", {31'h0, gap_timer_irq}, 32'h0);
    rchk("flag kept", `SIG_OFF_IFB, 32'h20, 32'h20);
    bus(1'b1, `SIG_OFF_MKB, 32'h0);
    gap_run(16'h0009, 16'h0100, 257);
    gap_run(16'h0809, 16'h017C, 125);
    gap_run(16'h0109, 16'h007C, 0);
    gap_run(16'h1009, 16'h007C, 0);
    gap_run(16'h4009, 16'h007C, 500);
    gap_run(16'h0009, 16'h007C, 125);
    $display("test gap timer done");
    bus(1'b1, `SIG_OFF_MKA, 32'h0);
    for (int i = 0; i < 2; i++) begin
      i2c_start;
      tx_byte(i ? 8'h70 : 8'h60, 1'b0, "write addr");
      repeat (4) gap_run(16'h0009, 16'h007C, 125);
      rchk("wait done", `SIG_OFF_WAIT, 32'h1FF, 32'h144);
      tx_byte(8'h3C, 1'b0, "write data");
      i2c_stop;
    end
    $display("test write frames done");
    for (int i = 0; i < 2; i++) begin
      i2c_start;
      tx_byte(i ? 8'h71 : 8'h61, 1'b0, "read addr");
      bus(1'b1, `SIG_OFF_SETUP, 32'h4017);
      bus(1'b1, `SIG_OFF_BUF, 32'hFF);
      poll(`SIG_OFF_STAT, 32'h20, 32'h0);
      rchk("rx data", `SIG_OFF_BUF, 32'hFF, 32'hA5);
      i2c_stop;
    end
    $display("test read frames done");
    i2c_start;
    tx_byte(8'h50, 1'b1, "bad addr");
    bus(1'b1, `SIG_OFF_ERRCLR, 32'h2);
    rchk("ack cleared", `SIG_OFF_STAT, 32'h2, 32'h0);
    i2c_stop;
    i2c_start;
    bus(1'b1, `SIG_OFF_BUF, 32'h60);
    i2c_stop;
    $display("test nack and abort done");
    final_report;
  end
endmodule
